// File: rtl/low_power_mode_gating.sv
`timescale 1ns/10ps
`default_nettype none
module low_power_mode_gating
(
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Pins and events from outside the clock domain
   input  wire logic        devmode_strap_in,
   input  wire logic        lin_wake_in,
   input  wire logic [3:0]  wake_inputs_in,
   input  wire logic        cyclic_wake_in,
   input  wire logic        regulator_overtemp_shutdown_in,
   input  wire logic        regulator_short_in,
   input  wire logic        undervoltage_in,
   input  wire logic        watchdog_trigger_fail_in,
   input  wire logic        reset_release_in,
   // Gated outputs
   output logic             main_regulator_out,
   output logic             watchdog_out,
   output logic             watchdog_long_window_out,
   output logic [2:0]       high_side_switches_out,
   output logic             bridge_driver_out,
   output logic             bridge_low_side_brake_out,
   output logic             charge_pump_out,
   output logic             current_sense_amp_out,
   output logic             lin_on_out,
   output logic             lin_wake_capable_out,
   output logic             lin_woken_out,
   output logic             cyclic_sense_out,
   output logic             cyclic_wake_out,
   output logic [3:0]       wake_enable_out,
   output logic             reset_output_pin_out,
   output logic             interrupt_pin_out,
   output logic             interrupt_pin_oe_out,
   output logic             interrupt_pullup_out
);
   localparam int NSYNC = 8 + lpm_gating_pkg::WAKE_IN_WIDTH;

   // Two-stage synchronisers for all asynchronous inputs
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   always_ff @(posedge clock_in)
   begin
      sync_a <= {devmode_strap_in, lin_wake_in, wake_inputs_in, cyclic_wake_in,
                 regulator_overtemp_shutdown_in, regulator_short_in, undervoltage_in,
                 watchdog_trigger_fail_in, reset_release_in};
      sync_b <= sync_a;
   end

   logic       strap_s;
   logic       lin_wake_s;
   logic [3:0] wk_s;
   logic       cyc_wake_s;
   logic       ot_s;
   logic       short_s;
   logic       uv_s;
   logic       wdfail_s;
   logic       rst_rel_s;
   assign {strap_s, lin_wake_s, wk_s, cyc_wake_s, ot_s, short_s, uv_s, wdfail_s, rst_rel_s} = sync_b;

   lpm_gating_pkg::mode_e mode;
   lpm_gating_pkg::mode_e next_mode;
   logic [15:0] cfg;
   logic        failure;
   logic        watchdog_fail_flag_flag;
   logic        devmode;
   logic        devmode_blocked;
   logic        strap_taken;
   logic        first_normal_done;
   logic        long_window;
   logic        park_brake;
   logic        ov_brake;
   logic        wake_pending;
   logic        lin_woken;
   logic [4:0]  wake_flags;
   logic        ot_seen;
   logic        wdfail_d;
   logic        irq;

   logic wr;
   logic rd;
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1;

   logic mapped;
   assign mapped = (paddr == lpm_gating_pkg::CTRL_ADDR) || (paddr == lpm_gating_pkg::CONFIG_ADDR) ||
                   (paddr == lpm_gating_pkg::STATUS_ADDR) || (paddr == lpm_gating_pkg::OUTS_ADDR);
   assign pslverr = psel && penable && !mapped;

   logic cmd_wr;
   assign cmd_wr = wr && (paddr == lpm_gating_pkg::CTRL_ADDR);

   logic in_fs;
   assign in_fs = (mode == lpm_gating_pkg::MODE_FAILSAFE);

   logic [3:0] wk_wake_cfg;
   assign wk_wake_cfg = cfg[lpm_gating_pkg::CFG_WKWAKE_LSB +: lpm_gating_pkg::WAKE_IN_WIDTH];

   // Default sources in Fail-Safe: LIN and wake-configured inputs
   logic default_wake;
   assign default_wake = lin_wake_s || ((wk_s & wk_wake_cfg) != 4'h0);

   logic sleep_wake;
   assign sleep_wake = default_wake || (cyc_wake_s && cfg[lpm_gating_pkg::CFG_CYCW_BIT]);

   logic wd_edge;
   assign wd_edge = wdfail_s && !wdfail_d;

   // Watchdog failure is ignored as a mode trigger in development mode
   logic wd_mode_trigger;
   assign wd_mode_trigger = wd_edge && !devmode && watchdog_out;

   logic filter_done;
   logic ot_done;

   mode_timer filter_timer
   (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .run_in   (in_fs),
      .load_in  (lpm_gating_pkg::FS_FILTER_CYCLES[31:0]),
      .done_out (filter_done)
   );

   mode_timer overtemp_timer
   (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .run_in   (in_fs && ot_seen && !ot_s),
      .load_in  (lpm_gating_pkg::OT_DELAY_CYCLES[31:0]),
      .done_out (ot_done)
   );

   always_comb
   begin
      next_mode = mode;
      case (mode)
         lpm_gating_pkg::MODE_INIT:
         begin
            if (short_s || ot_s)
               next_mode = lpm_gating_pkg::MODE_FAILSAFE;
            else if (wr && rst_rel_s)
               next_mode = lpm_gating_pkg::MODE_NORMAL;
         end
         lpm_gating_pkg::MODE_NORMAL, lpm_gating_pkg::MODE_STOP:
         begin
            if (ot_s || (cmd_wr && pwdata[lpm_gating_pkg::CMD_FAILSAFE_BIT]))
               next_mode = lpm_gating_pkg::MODE_FAILSAFE;
            else if (uv_s || wd_mode_trigger)
               next_mode = lpm_gating_pkg::MODE_RESTART;
            else if (cmd_wr && pwdata[lpm_gating_pkg::CMD_SLEEP_BIT] && mode == lpm_gating_pkg::MODE_NORMAL)
               next_mode = lpm_gating_pkg::MODE_SLEEP;
            else if (cmd_wr && pwdata[lpm_gating_pkg::CMD_STOP_BIT] && mode == lpm_gating_pkg::MODE_NORMAL)
               next_mode = lpm_gating_pkg::MODE_STOP;
            else if (cmd_wr && pwdata[lpm_gating_pkg::CMD_NORMAL_BIT])
               next_mode = lpm_gating_pkg::MODE_NORMAL;
         end
         lpm_gating_pkg::MODE_SLEEP:
         begin
            if (ot_s)
               next_mode = lpm_gating_pkg::MODE_FAILSAFE;
            else if (sleep_wake)
               next_mode = lpm_gating_pkg::MODE_RESTART;
         end
         lpm_gating_pkg::MODE_RESTART:
         begin
            if (rst_rel_s && !uv_s)
               next_mode = lpm_gating_pkg::MODE_NORMAL;
         end
         lpm_gating_pkg::MODE_FAILSAFE:
         begin
            // Leaving before the filter expires would let the system toggle fast
            if (ot_done || (filter_done && !ot_s && (wake_pending || default_wake)))
               next_mode = lpm_gating_pkg::MODE_RESTART;
         end
         default:
            next_mode = lpm_gating_pkg::MODE_INIT;
      endcase
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         mode <= lpm_gating_pkg::MODE_INIT;
      else
         mode <= next_mode;
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         cfg <= lpm_gating_pkg::CFG_RESET;
      else if (wr && paddr == lpm_gating_pkg::CONFIG_ADDR &&
               (mode == lpm_gating_pkg::MODE_NORMAL || mode == lpm_gating_pkg::MODE_INIT))
         cfg <= pwdata[lpm_gating_pkg::CFG_WIDTH-1:0];
   end

   // Strap caught on the first Init cycle; a regulator short on that cycle locks it out
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         devmode         <= 1'b0;
         strap_taken     <= 1'b0;
         devmode_blocked <= 1'b0;
      end
      else
      begin
         if (mode == lpm_gating_pkg::MODE_INIT && short_s)
            devmode_blocked <= 1'b1;
         if (!strap_taken && mode == lpm_gating_pkg::MODE_INIT && !short_s)
         begin
            strap_taken <= 1'b1;
            devmode     <= strap_s && !devmode_blocked;
         end
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         first_normal_done <= 1'b0;
      else if (mode == lpm_gating_pkg::MODE_NORMAL && cmd_wr)
         first_normal_done <= 1'b1;
   end

   // Every Restart exit reopens the long window, not only the first one after Init
   always_ff @(posedge clock_in)
   begin
      if (rst_in || mode == lpm_gating_pkg::MODE_RESTART)
         long_window <= 1'b1;
      else if (mode == lpm_gating_pkg::MODE_NORMAL && cmd_wr)
         long_window <= 1'b0;
   end

   // Fail-Safe wake store; entry clearing wins over arrival
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         wake_pending <= 1'b0;
         wake_flags   <= 5'h00;
         lin_woken    <= 1'b0;
         ot_seen      <= 1'b0;
      end
      else
      begin
         if (next_mode == lpm_gating_pkg::MODE_FAILSAFE && !in_fs)
         begin
            wake_pending <= 1'b0;
            wake_flags   <= 5'h00;
         end
         else
         begin
            if (in_fs && default_wake)
               wake_pending <= 1'b1;
            else if (!in_fs)
               wake_pending <= 1'b0;
            wake_flags <= wake_flags | {lin_wake_s, wk_s & wk_wake_cfg};
         end
         if ((mode == lpm_gating_pkg::MODE_SLEEP || in_fs) && lin_wake_s)
            lin_woken <= 1'b1;
         else if (mode == lpm_gating_pkg::MODE_NORMAL)
            lin_woken <= 1'b0;
         if (ot_s)
            ot_seen <= 1'b1;
         else if (!in_fs)
            ot_seen <= 1'b0;
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         failure <= 1'b0;
      else if (in_fs && next_mode != lpm_gating_pkg::MODE_FAILSAFE)
         failure <= 1'b1;
      else if (cmd_wr && pwdata[lpm_gating_pkg::CMD_FAILURE_CLR])
         failure <= 1'b0;
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         park_brake <= 1'b0;
         ov_brake   <= 1'b0;
      end
      else if (next_mode == lpm_gating_pkg::MODE_FAILSAFE)
      begin
         park_brake <= 1'b0;
         ov_brake   <= 1'b0;
      end
      else if (cmd_wr && mode == lpm_gating_pkg::MODE_NORMAL)
      begin
         park_brake <= pwdata[lpm_gating_pkg::CMD_PARK_BIT];
         ov_brake   <= pwdata[lpm_gating_pkg::CMD_OVBRK_BIT];
      end
   end

   // Watchdog fail flag and interrupt; set wins over clear
   logic wd_disabled;
   assign wd_disabled = devmode && cfg[lpm_gating_pkg::CFG_WDDIS_BIT];
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         wdfail_d     <= 1'b0;
         watchdog_fail_flag_flag <= 1'b0;
         irq          <= 1'b0;
      end
      else
      begin
         wdfail_d <= wdfail_s;
         if (wd_edge && watchdog_out && !wd_disabled)
            watchdog_fail_flag_flag <= 1'b1;
         else if (cmd_wr && pwdata[lpm_gating_pkg::CMD_WDFAIL_CLR])
            watchdog_fail_flag_flag <= 1'b0;
         // One pulse per failure, in development mode only; masking bit high means unmasked, low means flag only
         irq <= wd_edge && watchdog_out && devmode && !wd_disabled &&
                cfg[lpm_gating_pkg::CFG_WDMASK_BIT];
      end
   end

   // Output gating per mode
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         main_regulator_out        <= 1'b1;
         watchdog_out              <= 1'b0;
         watchdog_long_window_out  <= 1'b1;
         high_side_switches_out    <= 3'h0;
         bridge_driver_out         <= 1'b0;
         bridge_low_side_brake_out <= 1'b0;
         charge_pump_out           <= 1'b0;
         current_sense_amp_out     <= 1'b0;
         lin_on_out                <= 1'b0;
         lin_wake_capable_out      <= 1'b0;
         lin_woken_out             <= 1'b0;
         cyclic_sense_out          <= 1'b0;
         cyclic_wake_out           <= 1'b0;
         wake_enable_out           <= 4'h0;
         reset_output_pin_out      <= 1'b1;
      end
      else
      begin
         main_regulator_out        <= 1'b0;
         watchdog_out              <= 1'b0;
         watchdog_long_window_out  <= 1'b0;
         bridge_driver_out         <= 1'b0;
         bridge_low_side_brake_out <= 1'b0;
         charge_pump_out           <= 1'b0;
         current_sense_amp_out     <= 1'b0;
         lin_on_out                <= 1'b0;
         lin_wake_capable_out      <= 1'b0;
         lin_woken_out             <= 1'b0;
         cyclic_sense_out          <= 1'b0;
         cyclic_wake_out           <= 1'b0;
         wake_enable_out           <= wk_wake_cfg;
         reset_output_pin_out      <= 1'b0;
         case (mode)
            lpm_gating_pkg::MODE_INIT:
            begin
               main_regulator_out       <= 1'b1;
               watchdog_out             <= 1'b1;
               watchdog_long_window_out <= 1'b1;
               lin_on_out               <= devmode;
               reset_output_pin_out     <= !rst_rel_s;
            end
            lpm_gating_pkg::MODE_NORMAL, lpm_gating_pkg::MODE_STOP:
            begin
               main_regulator_out     <= 1'b1;
               watchdog_out           <= cfg[lpm_gating_pkg::CFG_WDEN_BIT] || (devmode && !wd_disabled);
               watchdog_long_window_out <= long_window;
               high_side_switches_out <= cfg[lpm_gating_pkg::CFG_HS_LSB +: lpm_gating_pkg::CFG_HS_WIDTH];
               bridge_driver_out      <= (mode == lpm_gating_pkg::MODE_NORMAL) && cfg[lpm_gating_pkg::CFG_BD_BIT];
               charge_pump_out        <= (mode == lpm_gating_pkg::MODE_NORMAL) && cfg[lpm_gating_pkg::CFG_CP_BIT];
               current_sense_amp_out  <= (mode == lpm_gating_pkg::MODE_NORMAL) && cfg[lpm_gating_pkg::CFG_CSA_BIT];
               bridge_low_side_brake_out <= park_brake || ov_brake;
               lin_on_out             <= cfg[lpm_gating_pkg::CFG_LIN_BIT] || (devmode && !first_normal_done);
               cyclic_sense_out       <= cfg[lpm_gating_pkg::CFG_CYCS_BIT];
               cyclic_wake_out        <= cfg[lpm_gating_pkg::CFG_CYCW_BIT];
            end
            lpm_gating_pkg::MODE_SLEEP:
            begin
               // Regulator, watchdog, bridge, pump and amplifier stay off
               high_side_switches_out    <= high_side_switches_out;
               lin_wake_capable_out      <= cfg[lpm_gating_pkg::CFG_LIN_BIT];
               cyclic_sense_out          <= cfg[lpm_gating_pkg::CFG_CYCS_BIT];
               cyclic_wake_out           <= cfg[lpm_gating_pkg::CFG_CYCW_BIT];
               bridge_low_side_brake_out <= park_brake || ov_brake;
               reset_output_pin_out      <= 1'b1;
            end
            lpm_gating_pkg::MODE_RESTART:
            begin
               reset_output_pin_out   <= 1'b1;
               high_side_switches_out <= 3'h0;
               main_regulator_out     <= 1'b1;
               lin_woken_out          <= lin_woken;
               lin_wake_capable_out   <= !lin_woken && cfg[lpm_gating_pkg::CFG_LIN_BIT];
               watchdog_long_window_out <= 1'b1;
            end
            lpm_gating_pkg::MODE_FAILSAFE:
            begin
               high_side_switches_out <= 3'h0;
               lin_wake_capable_out   <= 1'b1;
               wake_enable_out        <= wk_wake_cfg;
               reset_output_pin_out   <= 1'b1;
            end
            default:
               high_side_switches_out <= 3'h0;
         endcase
      end
   end

   // Interrupt pin: pulled up in Init, driven afterwards
   always_ff @(posedge clock_in)
   begin
      if (rst_in)
      begin
         interrupt_pin_out    <= 1'b0;
         interrupt_pin_oe_out <= 1'b0;
         interrupt_pullup_out <= 1'b1;
      end
      else
      begin
         interrupt_pin_out    <= irq;
         interrupt_pin_oe_out <= (mode != lpm_gating_pkg::MODE_INIT);
         interrupt_pullup_out <= (mode == lpm_gating_pkg::MODE_INIT);
      end
   end

   always_ff @(posedge clock_in)
   begin
      if (rst_in)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
      begin
         case (paddr)
            lpm_gating_pkg::CONFIG_ADDR:
               prdata <= {16'h0000, cfg};
            lpm_gating_pkg::STATUS_ADDR:
               prdata <= {19'h00000, wake_flags, wake_pending, devmode, watchdog_fail_flag_flag, failure, 1'b0, mode};
            lpm_gating_pkg::OUTS_ADDR:
               prdata <= {16'h0000, main_regulator_out, watchdog_out, high_side_switches_out, bridge_driver_out,
                          charge_pump_out, current_sense_amp_out, lin_on_out, lin_wake_capable_out,
                          lin_woken_out, cyclic_sense_out, cyclic_wake_out, reset_output_pin_out,
                          bridge_low_side_brake_out, park_brake};
            default:
               prdata <= 32'h0000_0000;
         endcase
      end
   end

   logic unused_rd;
   assign unused_rd = rd;
endmodule
`default_nettype wire

// File: rtl/mode_timer.sv
`timescale 1ns/10ps
`default_nettype none
// Countdown that runs while run_in is high; done_out is a level once expired
module mode_timer
(
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   input  wire logic        run_in,
   input  wire logic [31:0] load_in,
   output logic             done_out
);
   logic [31:0] count;

   always_ff @(posedge clock_in)
   begin
      if (rst_in || !run_in)
      begin
         count <= load_in;
      end
      else if (count != 32'h0000_0000)
      begin
         count <= count - 32'h0000_0001;
      end
   end

   assign done_out = run_in && (count == 32'h0000_0000);
endmodule
`default_nettype wire

// File: shared/lpm_gating_pkg.sv
`default_nettype none
package lpm_gating_pkg;
   // Register byte addresses
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] CONFIG_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   localparam logic [7:0] OUTS_ADDR   = 8'h0C;

   // Control register: one-shot commands, read as zero
   localparam int CMD_SLEEP_BIT    = 0;
   localparam int CMD_NORMAL_BIT   = 1;
   localparam int CMD_STOP_BIT     = 2;
   localparam int CMD_FAILSAFE_BIT = 3;
   localparam int CMD_PARK_BIT     = 4;
   localparam int CMD_OVBRK_BIT    = 5;
   localparam int CMD_WDFAIL_CLR   = 6;
   localparam int CMD_FAILURE_CLR  = 7;

   // Configuration register fields
   localparam int CFG_HS_LSB       = 0;
   localparam int CFG_HS_WIDTH     = 3;
   localparam int CFG_BD_BIT       = 3;
   localparam int CFG_CP_BIT       = 4;
   localparam int CFG_CSA_BIT      = 5;
   localparam int CFG_LIN_BIT      = 6;
   localparam int CFG_CYCS_BIT     = 7;
   localparam int CFG_CYCW_BIT     = 8;
   localparam int CFG_WDEN_BIT     = 9;
   localparam int CFG_WDDIS_BIT    = 10;
   localparam int CFG_WDMASK_BIT   = 11;
   localparam int CFG_WKWAKE_LSB   = 12;
   localparam int WAKE_IN_WIDTH    = 4;
   localparam int CFG_WIDTH        = 16;
   localparam logic [15:0] CFG_RESET = 16'h0000;

   // Status register fields
   localparam int ST_MODE_LSB      = 0;
   localparam int ST_FAILURE_BIT   = 4;
   localparam int ST_WDFAIL_BIT    = 5;
   localparam int ST_DEVMODE_BIT   = 6;
   localparam int ST_WKPEND_BIT    = 7;
   localparam int ST_WKFLAG_LSB    = 8;

   // Timing
   localparam int  CLK_MHZ             = 100;
   localparam int  FS_FILTER_MS        = 100;
   localparam int  OT_DELAY_MS         = 1000;
   localparam int  FS_FILTER_CYCLES    = FS_FILTER_MS * 1000 * CLK_MHZ;
   localparam int  OT_DELAY_CYCLES     = OT_DELAY_MS * 1000 * CLK_MHZ;
   localparam int  TIMER_WIDTH         = 32;

   typedef enum logic [2:0]
   {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAILSAFE
   } mode_e;
endpackage
`default_nettype wire

// File: verif/lpm_gating_sva.sv
`timescale 1ns/10ps
`default_nettype none
module lpm_gating_sva
(
   input wire logic       clock_in,
   input wire logic       rst_in,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pslverr,
   input wire logic       main_regulator_out,
   input wire logic       watchdog_out,
   input wire logic [2:0] high_side_switches_out,
   input wire logic       bridge_driver_out,
   input wire logic       charge_pump_out,
   input wire logic       current_sense_amp_out,
   input wire logic       cyclic_sense_out,
   input wire logic       cyclic_wake_out,
   input wire logic       reset_output_pin_out,
   input wire logic       interrupt_pin_out,
   input wire logic       interrupt_pin_oe_out,
   input wire logic       interrupt_pullup_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   AST_REG_OFF : assert property (!main_regulator_out |-> !(watchdog_out || bridge_driver_out
      || charge_pump_out || current_sense_amp_out)) else $error("load on with regulator off");
   // Init also holds the reset pin with the regulator up; only Init keeps the pull-up
   AST_RST_HS : assert property (reset_output_pin_out && main_regulator_out && !interrupt_pullup_out |->
      !watchdog_out && high_side_switches_out == 3'h0) else $error("switch on in reset");
   AST_RST_BD : assert property (reset_output_pin_out && main_regulator_out && !interrupt_pullup_out |->
      !(bridge_driver_out || charge_pump_out || current_sense_amp_out)) else $error("bridge on in reset");
   AST_RST_CYC : assert property (reset_output_pin_out && main_regulator_out && !interrupt_pullup_out |->
      !cyclic_sense_out && !cyclic_wake_out) else $error("cyclic on in reset");
   AST_INT_PULSE : assert property (interrupt_pin_out |=> !interrupt_pin_out)
      else $error("interrupt longer than one cycle");
   AST_INT_OE : assert property (interrupt_pin_out |-> interrupt_pin_oe_out) else $error("interrupt undriven");
   AST_OE_HOLD : assert property (interrupt_pin_oe_out |=> $stable(interrupt_pin_oe_out))
      else $error("pin drive dropped");
   AST_PULLUP : assert property (interrupt_pin_oe_out |-> !interrupt_pullup_out) else $error("pull-up kept");
   AST_ERR : assert property (pslverr |-> psel && penable) else $error("error outside access");
endmodule
bind low_power_mode_gating lpm_gating_sva checker_i (.*);
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        clock_in = 1'b0, rst_in = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h51D16A83;
   logic        pready, pslverr, wake_fire = 1'b0, reset_release_in = 1'b0, lin_wake_in, cyclic_wake_in;
   logic        devmode_strap_in = 1'b0, regulator_overtemp_shutdown_in = 1'b0, regulator_short_in = 1'b0;
   logic        undervoltage_in = 1'b0, watchdog_trigger_fail_in = 1'b0;
   logic [3:0]  wake_inputs_in, wake_enable_out;
   logic [2:0]  high_side_switches_out;
   logic        main_regulator_out, watchdog_out, watchdog_long_window_out, bridge_driver_out;
   logic        bridge_low_side_brake_out, charge_pump_out, current_sense_amp_out, lin_on_out;
   logic        lin_wake_capable_out, lin_woken_out, cyclic_sense_out, cyclic_wake_out;
   logic        reset_output_pin_out, interrupt_pin_out, interrupt_pin_oe_out, interrupt_pullup_out;
   logic [15:0] cfg;
   logic [32:0] exp_q[$];
   int          compares = 0, miscompares = 0, irq_seen = 0;
   always #5 clock_in = ~clock_in;
   low_power_mode_gating dut (.*);
   wake_source_model partner (.clock_in(clock_in), .fire_in(wake_fire), .lin_wake_out(lin_wake_in),
      .wake_inputs_out(wake_inputs_in), .cyclic_wake_out(cyclic_wake_in));
   function automatic logic [31:0] next_lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] want);
      compares++;
      if (seen !== want)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      @(posedge clock_in);
      while (pready !== 1'b1)
         @(posedge clock_in);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   // Outputs are read mid-cycle so the launching edge has landed
   task automatic settle(input int n);
      repeat (n) @(posedge clock_in);
      @(negedge clock_in);
   endtask
   task end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clock_in)
      if (psel && penable && pready && !pwrite && exp_q.size() > 0)
         chk({pslverr, prdata}, exp_q.pop_front());
   always @(posedge clock_in)
      if (interrupt_pin_out === 1'b1)
         irq_seen++;
   initial
   begin
      repeat (3000) @(posedge clock_in);
      miscompares++;
      end_of_test();
   end
   initial
   begin
      repeat (16) @(posedge clock_in);
      rst_in <= 1'b0;
      reset_release_in <= 1'b1;
      lfsr = next_lfsr(next_lfsr(lfsr));
      cfg = {lfsr[15:12], 3'h0, lfsr[8:7], 1'b1, lfsr[5:0]};
      rd(lpm_gating_pkg::STATUS_ADDR, 33'h0);
      rd(lpm_gating_pkg::CONFIG_ADDR, 33'h0);
      rd(8'h10, 33'h100000000);
      apb(1'b1, lpm_gating_pkg::CONFIG_ADDR, {16'h0, cfg});
      rd(lpm_gating_pkg::CONFIG_ADDR, {17'h0, cfg});
      rd(lpm_gating_pkg::STATUS_ADDR, 33'h1);
      settle(3);
      chk(33'({high_side_switches_out, interrupt_pin_oe_out}), 33'({cfg[2:0], 1'b1}));
      @(posedge clock_in) reset_release_in <= 1'b0;
      // Brake rides on the Sleep command: software is unpowered once Sleep is in
      apb(1'b1, lpm_gating_pkg::CTRL_ADDR, 32'h11);
      settle(3);
      chk(33'({main_regulator_out, watchdog_out, bridge_driver_out, charge_pump_out}), 33'h0);
      chk(33'({high_side_switches_out, lin_wake_capable_out, cyclic_sense_out, cyclic_wake_out}),
         33'({cfg[2:0], cfg[6], cfg[7], cfg[8]}));
      chk(33'(bridge_low_side_brake_out), 33'h1);
      @(posedge clock_in) wake_fire <= 1'b1;
      @(posedge clock_in) wake_fire <= 1'b0;
      settle(6);
      chk(33'({reset_output_pin_out, main_regulator_out, lin_woken_out, high_side_switches_out,
         cyclic_sense_out, cyclic_wake_out}), 33'hE0);
      @(posedge clock_in) reset_release_in <= 1'b1;
      settle(5);
      chk(33'({reset_output_pin_out, watchdog_long_window_out}), 33'h1);
      apb(1'b1, lpm_gating_pkg::CTRL_ADDR, 32'h8);
      settle(3);
      chk(33'({main_regulator_out, high_side_switches_out, cyclic_sense_out, bridge_low_side_brake_out,
         lin_wake_capable_out, wake_enable_out}), 33'({7'h1, cfg[15:12]}));
      rd(lpm_gating_pkg::STATUS_ADDR, 33'h5);
      settle(2);
      @(posedge clock_in);
      rst_in <= 1'b1;
      devmode_strap_in <= 1'b1;
      repeat (4) @(posedge clock_in);
      rst_in <= 1'b0;
      settle(3);
      chk(33'({lin_on_out, interrupt_pullup_out, reset_output_pin_out}), 33'h6);
      apb(1'b1, lpm_gating_pkg::CONFIG_ADDR, 32'h800);
      @(posedge clock_in) watchdog_trigger_fail_in <= 1'b1;
      settle(5);
      chk(33'({lin_on_out, watchdog_out}), 33'h3);
      chk(33'(irq_seen), 33'h1);
      rd(lpm_gating_pkg::STATUS_ADDR, 33'h61);
      settle(2);
      end_of_test();
   end
endmodule
`default_nettype wire

// File: verif/wake_source_model.sv
`timescale 1ns/10ps
`default_nettype none
// Bus wake held four cycles so the input synchroniser cannot miss it
module wake_source_model
(
   input  wire logic clock_in,
   input  wire logic fire_in,
   output logic      lin_wake_out,
   output logic [3:0] wake_inputs_out,
   output logic      cyclic_wake_out
);
   logic [3:0] hold = 4'h0;
   always_ff @(posedge clock_in)
      hold <= fire_in ? 4'hF : hold >> 1;
   assign lin_wake_out = |hold;
   assign wake_inputs_out = 4'h0;
   assign cyclic_wake_out = 1'b0;
endmodule
`default_nettype wire
